// [core/rstwd_ctrl.sv]
// reset controller with watchdog and sleep clock gating
// Summary of operation
// - standby keeps system clock sources, stops cpu, peripheral, rtc clocks.
// - extended standby like power-save, keeps sources, stops cpu, peripheral.
// - any active source enters reset at once, held until all release.
// - io drivers tristate immediately on reset entry, no clock needed.
// - reset loads program counter with vector and io registers initial.
// - sram kept over reset; access in flight may be corrupt.
// - reset vector is address 0, option moves it to boot start.
// - reset assertion works asynchronously without a running clock; here only por, brownout and debug port, the rest are clocked.
// - status flags per source, cleared only by power-on, accumulate.
// - after release: counter delay, oscillator start, calibration, then run.
// - a request during restart aborts it; start again from stage one.
// - disabled brownout forced on lowest level in erase or debug port.
// - reset pin low beyond min pulse recognised, held while low.
// - watchdog reset pulse lasts one to two 2MHz oscillator periods.
// - software reset bit raises reset within two cpu clocks.
// - watchdog counts 1kHz tick, eleven periods from 8ms to 8s.
// - enabled watchdog resets if not restarted before timeout.
// - window mode restart outside the window resets as a timeout.
// - watchdog runs in all modes from own clock, survives clock loss; here its tick is divided from ref_clk_i and stops with it.
// - watchdog settings change only via protection key; fuse locks them.
// - reset disables clocks except 32kHz oscillator, restart on 2MHz.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module rstwd_ctrl #(
   parameter int TICK_CYC = rstwd_pkg::TICK_CYC_DEF,
   parameter int RCNT_CYC = rstwd_pkg::RCNT_CYC_DEF,
   parameter int OSCUP_CYC = rstwd_pkg::OSCUP_CYC_DEF,
   parameter int CAL_CYC = rstwd_pkg::CAL_CYC_DEF
) (
   input wire logic ref_clk_i,
   input wire logic srst_i,
   input wire logic por_i,
   input wire logic bod_trip_i,
   input wire logic bod_fuse_en_i,
   input wire logic chip_erase_i,
   input wire logic pdp_enable_i,
   input wire logic pdp_reset_i,
   input wire logic ext_rst_n_i,
   input wire logic wd_fuse_lock_i,
   input wire logic wdr_i,
   input wire logic sleep_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic core_rst_o,
   output logic io_hiz_o,
   output logic [15:0] pc_load_o,
   output logic sram_guard_o,
   output logic bod_active_o,
   output logic osc2m_en_o,
   output logic osc_cal_o,
   output logic sysclk_src_en_o,
   output logic cpu_clk_en_o,
   output logic per_clk_en_o,
   output logic rtc_clk_en_o
);
   localparam int WDW = 24;
   localparam int TW = 24;

   typedef struct packed {
      rstwd_pkg::rstwd_phase_type ph;
      logic [TW-1:0] tcnt;
      logic [7:0] rdata;
      logic [rstwd_pkg::NSRC-1:0] flags;
      logic bootsel;
      logic [7:0] wdcfg;
      logic [7:0] wdwin;
      logic [2:0] smode;
      logic ccp_open;
      logic [TW-1:0] tick_div;
      logic [WDW-1:0] wd_cnt;
      logic [7:0] wdrst_cnt;
      logic [7:0] ext_cnt;
      logic ext_held;
      logic sw_req;
      logic asleep;
      logic [15:0] pc;
      logic hold;
      logic bod_act;
      logic clk_cpu;
      logic clk_per;
      logic clk_rtc;
      logic clk_src;
      logic osc2m;
      logic cal;
   } rstwd_state_type;

   rstwd_state_type s_q;
   rstwd_state_type s_d;

   ////////////////////////////////////////////////////////////////////////
   // watchdog period table, ticks of 1ms: 8ms doubling to 8s
   logic [WDW-1:0] per_tab [rstwd_pkg::NPER];
   generate
      for (genvar g = 0; g < rstwd_pkg::NPER; g++) begin : g_per
         assign per_tab[g] = WDW'(8 << g);
      end
   endgenerate

   logic [3:0] per_sel;
   logic [3:0] win_sel;
   logic [WDW-1:0] wd_limit;
   logic [WDW-1:0] win_open;
   assign per_sel = s_q.wdcfg[rstwd_pkg::WD_PER_LSB +: 4];
   assign win_sel = s_q.wdwin[3:0];
   assign wd_limit = (per_sel < 4'(rstwd_pkg::NPER)) ?
                     per_tab[per_sel] : per_tab[rstwd_pkg::NPER-1];
   assign win_open = (win_sel < 4'(rstwd_pkg::NPER)) ?
                     per_tab[win_sel] : per_tab[rstwd_pkg::NPER-1];

   ////////////////////////////////////////////////////////////////////////
   // asynchronous reset assertion: por, brownout and debug port need no clock
   logic bod_on;
   logic async_req;
   logic sync_req;
   logic any_req;
   assign bod_on = bod_fuse_en_i | chip_erase_i | pdp_enable_i;
   assign async_req = por_i | (bod_on & bod_trip_i) | pdp_reset_i;
   assign sync_req = s_q.ext_held | (s_q.wdrst_cnt != 8'h00) | s_q.sw_req;
   assign any_req = async_req | sync_req;

   logic wd_en;
   logic wd_win;
   logic wd_expire;
   logic wd_bad_wdr;
   assign wd_en = s_q.wdcfg[rstwd_pkg::WD_EN_BIT];
   assign wd_win = s_q.wdcfg[rstwd_pkg::WD_WIN_BIT];
   assign wd_expire = wd_en && s_q.wd_cnt >= wd_limit;
   // restart too early counts the same as too late
   assign wd_bad_wdr = wd_en && wd_win && wdr_i &&
                       s_q.wd_cnt < win_open;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d = s_q;
      s_d.rdata = 8'h00;
      // pin filter: low beyond min pulse, held while low
      if (!ext_rst_n_i) begin
         if (s_q.ext_cnt < 8'(rstwd_pkg::TEXT_CYC)) begin
            s_d.ext_cnt = s_q.ext_cnt + 8'h01;
         end else begin
            s_d.ext_held = 1'b1;
         end
      end else begin
         s_d.ext_cnt = 8'h00;
         s_d.ext_held = 1'b0;
      end
      // watchdog: free tick, runs during sleep too
      if (s_q.tick_div >= TW'(TICK_CYC - 1)) begin
         s_d.tick_div = '0;
      end else begin
         s_d.tick_div = s_q.tick_div + TW'(1);
      end
      if (s_q.wdrst_cnt != 8'h00) begin
         s_d.wdrst_cnt = s_q.wdrst_cnt - 8'h01;
      end
      if (!wd_en || (wdr_i && !wd_bad_wdr)) begin
         s_d.wd_cnt = '0;
      end else if (wd_expire || wd_bad_wdr) begin
         s_d.wd_cnt = '0;
         s_d.wdrst_cnt = 8'(rstwd_pkg::WDRST_CYC);
         s_d.flags[rstwd_pkg::FLAG_WDT] = 1'b1;
      end else if (s_q.tick_div == '0) begin
         s_d.wd_cnt = s_q.wd_cnt + WDW'(1);
      end
      // register writes
      s_d.ccp_open = 1'b0;
      if (wr_i) begin
         case (addr_i)
            rstwd_pkg::CCP_OFS: s_d.ccp_open = (wdata_i == rstwd_pkg::CCP_KEY);
            rstwd_pkg::CTRL_OFS: begin
               if (s_q.ccp_open && wdata_i[rstwd_pkg::SWRST_BIT]) begin
                  s_d.sw_req = 1'b1;
               end
               s_d.bootsel = wdata_i[rstwd_pkg::BOOTSEL_BIT];
            end
            rstwd_pkg::WDCFG_OFS: begin
               if (s_q.ccp_open && !wd_fuse_lock_i) begin
                  s_d.wdcfg = wdata_i;
                  s_d.wd_cnt = '0;
               end
            end
            rstwd_pkg::WDWIN_OFS: begin
               if (s_q.ccp_open && !wd_fuse_lock_i) begin
                  s_d.wdwin = wdata_i;
               end
            end
            rstwd_pkg::SLEEP_OFS: s_d.smode = wdata_i[2:0];
            // read-only: software must not erase the reset history
            rstwd_pkg::STATUS_OFS: ;
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            rstwd_pkg::CTRL_OFS: s_d.rdata = {6'h00, s_q.bootsel, 1'b0};
            rstwd_pkg::STATUS_OFS: s_d.rdata = {2'b00, s_q.flags};
            rstwd_pkg::WDCFG_OFS: s_d.rdata = s_q.wdcfg;
            rstwd_pkg::WDWIN_OFS: s_d.rdata = s_q.wdwin;
            rstwd_pkg::SLEEP_OFS: s_d.rdata = {5'h00, s_q.smode};
            default: s_d.rdata = 8'h00;
         endcase
      end
      // source flags accumulate; power-on clear wins over every set
      if (s_q.ext_held) s_d.flags[rstwd_pkg::FLAG_EXT] = 1'b1;
      if (bod_on && bod_trip_i) s_d.flags[rstwd_pkg::FLAG_BOD] = 1'b1;
      if (pdp_reset_i) s_d.flags[rstwd_pkg::FLAG_PDP] = 1'b1;
      if (s_q.sw_req) s_d.flags[rstwd_pkg::FLAG_SW] = 1'b1;
      if (por_i) begin
         s_d.flags = '0;
         s_d.flags[rstwd_pkg::FLAG_POR] = 1'b1;
         s_d.wdcfg = rstwd_pkg::WDCFG_RST;
         s_d.wdwin = rstwd_pkg::WDWIN_RST;
      end
      // sleep entry and wake
      if (sleep_i) s_d.asleep = 1'b1;
      if (wdr_i) s_d.asleep = 1'b0;
      // restart sequencer
      s_d.tcnt = s_q.tcnt + TW'(1);
      case (s_q.ph)
         rstwd_pkg::ST_HOLD: begin
            s_d.tcnt = '0;
            if (!any_req) s_d.ph = rstwd_pkg::ST_RCNT;
         end
         rstwd_pkg::ST_RCNT: begin
            if (s_q.tcnt >= TW'(RCNT_CYC - 1)) begin
               s_d.ph = rstwd_pkg::ST_OSCUP;
               s_d.tcnt = '0;
            end
         end
         rstwd_pkg::ST_OSCUP: begin
            if (s_q.tcnt >= TW'(OSCUP_CYC - 1)) begin
               s_d.ph = rstwd_pkg::ST_CAL;
               s_d.tcnt = '0;
            end
         end
         rstwd_pkg::ST_CAL: begin
            if (s_q.tcnt >= TW'(CAL_CYC - 1)) begin
               s_d.ph = rstwd_pkg::ST_RUN;
               s_d.tcnt = '0;
            end
         end
         rstwd_pkg::ST_RUN: s_d.tcnt = '0;
         default: s_d.ph = rstwd_pkg::ST_HOLD;
      endcase
      if (any_req) begin
         s_d.ph = rstwd_pkg::ST_HOLD;
         s_d.tcnt = '0;
         s_d.sw_req = 1'b0;
         s_d.smode = rstwd_pkg::SLP_IDLE;
         s_d.asleep = 1'b0;
         s_d.bootsel = s_q.bootsel;
      end
      if (s_q.sw_req) s_d.sw_req = 1'b0;
      s_d.hold = (s_d.ph != rstwd_pkg::ST_RUN);
      s_d.pc = s_q.bootsel ? rstwd_pkg::BOOT_ADDR_DEF
                           : rstwd_pkg::RESET_ADDR;
      s_d.bod_act = bod_on;
      // oscillator controls registered so the pins carry no decode glitch
      s_d.osc2m = (s_d.ph != rstwd_pkg::ST_HOLD) &&
                  (s_d.ph != rstwd_pkg::ST_RCNT);
      s_d.cal = (s_d.ph == rstwd_pkg::ST_CAL);
      // clock gating per sleep mode
      s_d.clk_src = 1'b1;
      s_d.clk_cpu = !s_q.asleep;
      s_d.clk_per = 1'b1;
      s_d.clk_rtc = 1'b1;
      if (s_q.asleep) begin
         case (s_q.smode)
            rstwd_pkg::SLP_IDLE: ;
            rstwd_pkg::SLP_PDOWN: begin
               s_d.clk_src = 1'b0;
               s_d.clk_per = 1'b0;
               s_d.clk_rtc = 1'b0;
            end
            rstwd_pkg::SLP_PSAVE: begin
               s_d.clk_src = 1'b0;
               s_d.clk_per = 1'b0;
            end
            rstwd_pkg::SLP_STBY: begin
               s_d.clk_per = 1'b0;
               s_d.clk_rtc = 1'b0;
            end
            rstwd_pkg::SLP_ESTBY: s_d.clk_per = 1'b0;
            default: ;
         endcase
      end
      // in reset only the 32kHz source survives; 2MHz restarts at oscup
      if (s_d.hold) begin
         s_d.clk_src = 1'b0;
         s_d.clk_cpu = 1'b0;
         s_d.clk_per = 1'b0;
         s_d.clk_rtc = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s_q <= '0;
         s_q.ph <= rstwd_pkg::ST_HOLD;
         s_q.hold <= 1'b1;
         s_q.wdcfg <= rstwd_pkg::WDCFG_RST;
         s_q.wdwin <= rstwd_pkg::WDWIN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // reset and tristate asserted combinationally with the async request;
   // sram accesses are fenced while held; memory contents are not touched
   always_comb begin
      core_rst_o = s_q.hold | async_req;
      io_hiz_o = s_q.hold | async_req;
      sram_guard_o = s_q.hold | async_req;
   end
   assign rdata_o = s_q.rdata;
   assign pc_load_o = s_q.pc;
   assign bod_active_o = s_q.bod_act;
   assign osc2m_en_o = s_q.osc2m;
   assign osc_cal_o = s_q.cal;
   assign sysclk_src_en_o = s_q.clk_src;
   assign cpu_clk_en_o = s_q.clk_cpu;
   assign per_clk_en_o = s_q.clk_per;
   assign rtc_clk_en_o = s_q.clk_rtc;

   ////////////////////////////////////////////////////////////////////////
   sequence restart_seq;
      s_q.ph == rstwd_pkg::ST_HOLD ##1 s_q.ph == rstwd_pkg::ST_RCNT;
   endsequence
   sw_reset_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      wr_i && addr_i == rstwd_pkg::CTRL_OFS && s_q.ccp_open && wdata_i[0]
      |-> ##[1:2] core_rst_o) else $error("sw reset late");
   req_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      any_req |=> s_q.ph == rstwd_pkg::ST_HOLD)
      else $error("reset request not held");
   io_tristate_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      async_req |-> io_hiz_o) else $error("io not tristated");
   restart_abort_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_q.ph == rstwd_pkg::ST_OSCUP && any_req |=> s_q.ph == rstwd_pkg::ST_HOLD)
      else $error("restart not aborted");
   stage_order_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      restart_seq |-> s_q.tcnt == '0) else $error("bad stage entry");
   por_flag_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      por_i |=> s_q.flags[rstwd_pkg::FLAG_POR])
      else $error("por flag missing");
   bod_force_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      pdp_enable_i |=> bod_active_o) else $error("bod not forced");
   wd_lock_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      wd_fuse_lock_i && !por_i |=> $stable(s_q.wdcfg))
      else $error("locked wdt changed");
   wd_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      $rose(s_q.wdrst_cnt != 8'h00) |-> (s_q.wdrst_cnt != 8'h00) [*8])
      else $error("wdt pulse short");
   stby_clk_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_q.asleep && s_q.smode == rstwd_pkg::SLP_STBY && !s_d.hold
      |=> sysclk_src_en_o && !rtc_clk_en_o) else $error("standby");
   ext_hold_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_q.ext_held |=> core_rst_o)
      else $error("pin reset not held");
   status_ro_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      !por_i |=> ($past(s_q.flags) & ~s_q.flags) == 6'h00)
      else $error("status flag cleared");
   cal_order_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      $rose(osc_cal_o) |-> $past(osc2m_en_o))
      else $error("calibration before start-up");
   hold_clk_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
      s_q.hold |-> !cpu_clk_en_o && !sysclk_src_en_o)
      else $error("clocks on in reset");
endmodule : rstwd_ctrl

// [core/rstwd_pkg.sv]
// package for the reset and watchdog controller
package rstwd_pkg;
   // register offsets (byte addresses, 8-bit data)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] WDCFG_OFS = 8'h08;
   localparam logic [7:0] WDWIN_OFS = 8'h0c;
   localparam logic [7:0] CCP_OFS = 8'h10;
   localparam logic [7:0] SLEEP_OFS = 8'h14;
   localparam logic [7:0] BOOTVEC_OFS = 8'h18;
   localparam logic [7:0] CCP_KEY = 8'hd8;
   // status flag positions
   localparam int FLAG_POR = 0;
   localparam int FLAG_EXT = 1;
   localparam int FLAG_BOD = 2;
   localparam int FLAG_WDT = 3;
   localparam int FLAG_PDP = 4;
   localparam int FLAG_SW = 5;
   localparam int NSRC = 6;
   // control bit positions
   localparam int SWRST_BIT = 0;
   localparam int BOOTSEL_BIT = 1;
   // watchdog config fields
   localparam int WD_EN_BIT = 0;
   localparam int WD_WIN_BIT = 1;
   localparam int WD_PER_LSB = 2;
   localparam logic [7:0] WDCFG_RST = 8'h00;
   localparam logic [7:0] WDWIN_RST = 8'h00;
   localparam int NPER = 11;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int CLK_NS = 10;
   localparam int OSC2M_NS = 500;
   localparam int WDRST_CYC = (OSC2M_NS + CLK_NS - 1) / CLK_NS;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
   localparam int TEXT_NS = 1000;
   localparam int TEXT_CYC = (TEXT_NS + CLK_NS - 1) / CLK_NS;
   localparam int RCNT_CYC_DEF = 6400;
   localparam int OSCUP_CYC_DEF = 6400;
   localparam int CAL_CYC_DEF = 1000;
   localparam logic [15:0] BOOT_ADDR_DEF = 16'h7800;
   localparam logic [15:0] RESET_ADDR = 16'h0000;
   // sleep modes
   localparam logic [2:0] SLP_IDLE = 3'h0;
   localparam logic [2:0] SLP_PDOWN = 3'h2;
   localparam logic [2:0] SLP_PSAVE = 3'h3;
   localparam logic [2:0] SLP_STBY = 3'h6;
   localparam logic [2:0] SLP_ESTBY = 3'h7;
   typedef enum logic [2:0] {
      ST_HOLD, ST_RCNT, ST_OSCUP, ST_CAL, ST_RUN
   } rstwd_phase_type;
endpackage : rstwd_pkg

// [bench/rstwd_src_model.sv]
// model of the reset sources outside the controller
`timescale 1ns/1ps
module rstwd_src_model (
   input wire logic clk_i,
   input wire logic pdp_enable_i,
   output logic por_o,
   output logic bod_trip_o,
   output logic ext_rst_n_o,
   output logic pdp_reset_o
);
   // reset pin idles high through its pull-up
   initial begin
      por_o = 1'b0;
      bod_trip_o = 1'b0;
      ext_rst_n_o = 1'b1;
      pdp_reset_o = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // 0 power-on, 1 brownout, 2 reset pin, 3 debug port
   task automatic set_req(input int src);
      @(posedge clk_i);
      case (src)
         0: por_o <= 1'b1;
         1: bod_trip_o <= 1'b1;
         2: ext_rst_n_o <= 1'b0;
         // the debug reset exists only while a programmer is attached
         default: if (pdp_enable_i) pdp_reset_o <= 1'b1;
      endcase
   endtask : set_req
   task automatic release_all();
      @(posedge clk_i);
      por_o <= 1'b0;
      bod_trip_o <= 1'b0;
      ext_rst_n_o <= 1'b1;
      pdp_reset_o <= 1'b0;
   endtask : release_all
endmodule : rstwd_src_model

// [bench/test_reset_and_watchdog_control.sv]
// self-checking bench for the reset and watchdog controller
`timescale 1ns/1ps
module test_reset_and_watchdog_control;
   logic ref_clk_i, srst_i, bod_fuse_en_i, chip_erase_i, pdp_enable_i;
   logic wd_fuse_lock_i, wdr_i, sleep_i, wr_i, rd_i;
   logic [7:0] addr_i, wdata_i, rdata, d;
   logic por, bod_trip, ext_rst_n, pdp_reset, core_rst, io_hiz, sram_guard;
   logic bod_active, osc2m_en, osc_cal, src_en, cpu_en, per_en, rtc_en;
   logic [15:0] pc_load;
   int err_count = 0;
   int n_tests = 0;
   int n0, n;
   rstwd_ctrl #(.TICK_CYC(10), .RCNT_CYC(4), .OSCUP_CYC(4), .CAL_CYC(4))
   i_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .por_i(por),
      .bod_trip_i(bod_trip), .bod_fuse_en_i(bod_fuse_en_i),
      .chip_erase_i(chip_erase_i), .pdp_enable_i(pdp_enable_i),
      .pdp_reset_i(pdp_reset), .ext_rst_n_i(ext_rst_n),
      .wd_fuse_lock_i(wd_fuse_lock_i), .wdr_i(wdr_i), .sleep_i(sleep_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata), .core_rst_o(core_rst), .io_hiz_o(io_hiz),
      .pc_load_o(pc_load), .sram_guard_o(sram_guard),
      .bod_active_o(bod_active), .osc2m_en_o(osc2m_en), .osc_cal_o(osc_cal),
      .sysclk_src_en_o(src_en), .cpu_clk_en_o(cpu_en),
      .per_clk_en_o(per_en), .rtc_clk_en_o(rtc_en));
   rstwd_src_model i_src (.clk_i(ref_clk_i), .pdp_enable_i(pdp_enable_i),
      .por_o(por), .bod_trip_o(bod_trip), .ext_rst_n_o(ext_rst_n),
      .pdp_reset_o(pdp_reset));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk1(input logic got, input logic exp, input string m);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk1
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
      input string m);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s %h", $time, m, got);
      end
   endtask : chk8
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   // key write and protected write back to back, strobe held high
   task automatic pwr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr_i <= rstwd_pkg::CCP_OFS;
      wdata_i <= rstwd_pkg::CCP_KEY;
      wr_i <= 1'b1;
      @(posedge ref_clk_i);
      addr_i <= a;
      wdata_i <= v;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : pwr
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   task automatic pulse_wdr();
      @(posedge ref_clk_i);
      wdr_i <= 1'b1;
      @(posedge ref_clk_i);
      wdr_i <= 1'b0;
   endtask : pulse_wdr
   task automatic pulse_sleep(input logic [7:0] mode);
      wr(rstwd_pkg::SLEEP_OFS, mode);
      @(posedge ref_clk_i);
      sleep_i <= 1'b1;
      @(posedge ref_clk_i);
      sleep_i <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      #1;
   endtask : pulse_sleep
   task automatic wait_run(output int cnt);
      logic cal;
      cal = 1'b0;
      cnt = 0;
      while (core_rst !== 1'b0 && cnt < 300) begin
         @(posedge ref_clk_i);
         #1;
         cal = cal | (osc_cal === 1'b1);
         cnt++;
      end
      chk1(cnt < 300, 1'b1, "restart hangs");
      chk1(cal, 1'b1, "no calibration stage");
   endtask : wait_run
   // bounded wait for reset entry, used after watchdog faults
   task automatic wait_rst(input int lim);
      n = 0;
      while (core_rst !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         #1;
         n++;
      end
   endtask : wait_rst
   ////////////////////////////////////////////////////////////////////////
   task automatic t_por();
      i_src.set_req(0);
      #1;
      chk1(core_rst, 1'b1, "no async reset");
      chk1(io_hiz, 1'b1, "io not tristated");
      chk1(sram_guard, 1'b1, "sram not guarded");
      chk1(osc2m_en, 1'b0, "2MHz running in reset");
      chk1(src_en, 1'b0, "clock source on in reset");
      repeat (5) @(posedge ref_clk_i);
      i_src.release_all();
      wait_run(n0);
      chk1(osc2m_en, 1'b1, "not restarted on 2MHz");
      chk8(pc_load[7:0], 8'h00, "vector");
      chk8(pc_load[15:8], 8'h00, "vector");
      rd(rstwd_pkg::STATUS_OFS);
      chk8(d & 8'h3f, 8'h01, "status after por");
      wr(rstwd_pkg::STATUS_OFS, 8'h3f);
      rd(rstwd_pkg::STATUS_OFS);
      chk8(d, 8'h01, "status cleared by software");
      rd(rstwd_pkg::WDCFG_OFS);
      chk8(d, rstwd_pkg::WDCFG_RST, "wdcfg reset");
      rd(8'h40);
      chk8(d, 8'h00, "unmapped read");
      $display("test por done");
   endtask : t_por
   task automatic t_abort();
      pdp_enable_i <= 1'b1;
      i_src.set_req(0);
      i_src.release_all();
      repeat (6) @(posedge ref_clk_i);
      i_src.set_req(3);
      i_src.release_all();
      wait_run(n);
      chk1(n == n0, 1'b1, "restart not from first stage");
      pdp_enable_i <= 1'b0;
      $display("test abort done");
   endtask : t_abort
   task automatic t_ext();
      i_src.set_req(2);
      repeat (30) @(posedge ref_clk_i);
      i_src.release_all();
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b0, "short pin pulse reset");
      i_src.set_req(2);
      repeat (150) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b1, "pin held low, no reset");
      i_src.release_all();
      wait_run(n);
      rd(rstwd_pkg::STATUS_OFS);
      chk8(d & 8'h13, 8'h13, "flags not accumulated");
      $display("test ext done");
   endtask : t_ext
   task automatic t_bod();
      i_src.set_req(1);
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b0, "disabled brownout reset");
      i_src.release_all();
      chip_erase_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk1(bod_active, 1'b1, "brownout not forced");
      i_src.set_req(1);
      #1;
      chk1(core_rst, 1'b1, "forced brownout no reset");
      i_src.release_all();
      chip_erase_i <= 1'b0;
      wait_run(n);
      rd(rstwd_pkg::STATUS_OFS);
      chk1(d[rstwd_pkg::FLAG_BOD], 1'b1, "brownout flag");
      bod_fuse_en_i <= 1'b1;
      i_src.set_req(1);
      #1;
      chk1(core_rst, 1'b1, "fuse brownout no reset");
      i_src.release_all();
      bod_fuse_en_i <= 1'b0;
      wait_run(n);
      $display("test bod done");
   endtask : t_bod
   task automatic t_swrst();
      wr(rstwd_pkg::CTRL_OFS, 8'h03);
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b0, "unkeyed soft reset");
      pwr(rstwd_pkg::CTRL_OFS, 8'h03);
      repeat (2) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b1, "soft reset late");
      wait_run(n);
      chk8(pc_load[15:8], 8'h78, "boot vector");
      rd(rstwd_pkg::STATUS_OFS);
      chk1(d[rstwd_pkg::FLAG_SW], 1'b1, "software flag");
      $display("test swrst done");
   endtask : t_swrst
   task automatic t_wd_timeout();
      wd_fuse_lock_i <= 1'b1;
      pwr(rstwd_pkg::WDCFG_OFS, 8'h01);
      rd(rstwd_pkg::WDCFG_OFS);
      chk8(d, 8'h00, "locked config changed");
      wd_fuse_lock_i <= 1'b0;
      pwr(rstwd_pkg::WDCFG_OFS, 8'h01);
      repeat (60) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b0, "watchdog early");
      wait_rst(60);
      chk1(core_rst, 1'b1, "no watchdog reset");
      wait_run(n);
      rd(rstwd_pkg::STATUS_OFS);
      chk1(d[rstwd_pkg::FLAG_WDT], 1'b1, "watchdog flag");
      $display("test wd timeout done");
   endtask : t_wd_timeout
   task automatic t_wd_kick();
      pwr(rstwd_pkg::WDCFG_OFS, 8'h01);
      repeat (6) begin
         repeat (40) @(posedge ref_clk_i);
         pulse_wdr();
         #1;
         chk1(core_rst, 1'b0, "kicked watchdog reset");
      end
      pulse_sleep(rstwd_pkg::SLP_STBY);
      chk1(cpu_en, 1'b0, "standby cpu clock");
      chk1(per_en, 1'b0, "standby peripheral clock");
      chk1(rtc_en, 1'b0, "standby rtc clock");
      chk1(src_en, 1'b1, "standby sources");
      wait_rst(150);
      chk1(core_rst, 1'b1, "watchdog dead in sleep");
      wait_run(n);
      pulse_sleep(rstwd_pkg::SLP_ESTBY);
      chk1(cpu_en, 1'b0, "ext standby cpu clock");
      chk1(per_en, 1'b0, "ext standby peripheral clock");
      chk1(rtc_en, 1'b1, "ext standby rtc clock");
      chk1(src_en, 1'b1, "ext standby sources");
      pulse_wdr();
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk1(cpu_en, 1'b1, "no wake");
      $display("test wd kick and sleep done");
   endtask : t_wd_kick
   task automatic t_window();
      // closed 8 ticks, timeout 16 ticks
      pwr(rstwd_pkg::WDWIN_OFS, 8'h00);
      pwr(rstwd_pkg::WDCFG_OFS, 8'h07);
      repeat (120) @(posedge ref_clk_i);
      pulse_wdr();
      repeat (3) @(posedge ref_clk_i);
      #1;
      chk1(core_rst, 1'b0, "restart in window reset");
      repeat (20) @(posedge ref_clk_i);
      pulse_wdr();
      wait_rst(10);
      chk1(core_rst, 1'b1, "early restart ignored");
      wait_run(n);
      $display("test window done");
   endtask : t_window
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // the whole sequence needs roughly 1100 cycles
   initial begin
      #200000;
      err_count++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
   end
   initial begin
      srst_i = 1'b1;
      // level inputs and idle strobes start low together
      {bod_fuse_en_i, chip_erase_i, pdp_enable_i, wd_fuse_lock_i} = 4'h0;
      {wdr_i, sleep_i, wr_i, rd_i} = 4'h0;
      {addr_i, wdata_i} = 16'h0000;
      repeat (2) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      t_por();
      t_abort();
      t_ext();
      t_bod();
      t_swrst();
      t_wd_timeout();
      t_wd_kick();
      t_window();
      report_and_stop();
   end
endmodule : test_reset_and_watchdog_control
